// ===== design/rmb_reading_memory.sv
// Reading memory: circular store of readings, drained or queried over Wishbone.
// Assumes readings arrive as one-cycle strobes and the bus is classic Wishbone.
`timescale 1ns/10ps
module rmb_reading_memory (
    input wire logic sys_clk,
    input wire logic rst_n,
    input rmb_pkg::rmb_wb_req_s wbReq,
    output logic wbAck_reg,
    output logic [31:0] wbDatO_reg,
    input wire logic rdgValid,
    input rmb_pkg::rmb_reading_s rdgIn,
    output logic irq
);
    import rmb_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_WAITN, ST_DRAIN, ST_LSCAN, ST_LEMIT} rmb_state_e;

    function automatic logic [31:0] applySel(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
                r[8*b +: 8] = nw[8*b +: 8];
        end
        return r;
    endfunction

    function automatic logic [IDXW-1:0] nextIdx(input logic [IDXW-1:0] i);
        return (i == DEPTH_M1) ? IDX_ZERO : IDXW'(i + IDX_ONE);
    endfunction

    function automatic logic [IDXW-1:0] prevIdx(input logic [IDXW-1:0] i);
        return (i == IDX_ZERO) ? DEPTH_M1 : IDXW'(i - IDX_ONE);
    endfunction

    rmb_state_e state_reg;
    logic [IDXW-1:0] wrPtr_reg, rdPtr_reg, count_reg, count_next;
    logic [IDXW-1:0] threshold_reg, reqNum_reg, remain_reg;
    logic [IDXW-1:0] scanIdx_reg, scanLeft_reg, found_reg, startIdx_reg;
    logic [15:0] reqChan_reg;
    rmb_reading_s outData_reg, dataA, dataB;
    logic outValid_reg, err_reg, errPulse_reg, operThr_reg, questOvf_reg;
    logic busAcc, busWr, busRd, cmdWr, clsCmd, cmdGo, cmdWait, numBad;
    logic full, popNow, overflow, thrHit, dataRd, operRd;
    logic scanHit, scanDone, emitHit;
    logic [31:0] numMerge, chanMerge, thrMerge;
    rmb_op_e cmdOp;
    logic [NIRQ-1:0] irqStatus, irqMask, irqEvt;

    always_comb
    begin
        busAcc = wbReq.cyc && wbReq.stb && !wbAck_reg;
        busWr = busAcc && wbReq.we;
        busRd = busAcc && !wbReq.we;
        cmdWr = busWr && (wbReq.adr == OFF_CMD);
        clsCmd = cmdWr && wbReq.dat[CMD_CLS_BIT];
        cmdGo = cmdWr && !clsCmd && (state_reg == ST_IDLE);
        cmdOp = rmb_op_e'(wbReq.dat[CMD_OP_LSB +: 2]);
        cmdWait = wbReq.dat[CMD_WAIT_BIT];
        numBad = (reqNum_reg == IDX_ZERO) || (reqNum_reg > DEPTH);
        dataRd = busRd && (wbReq.adr == OFF_DATA);
        operRd = busRd && (wbReq.adr == OFF_OPER);
        numMerge = applySel(32'(reqNum_reg), wbReq.dat, wbReq.sel);
        chanMerge = applySel(32'(reqChan_reg), wbReq.dat, wbReq.sel);
        thrMerge = applySel(32'(threshold_reg), wbReq.dat, wbReq.sel);
    end

    // pop only while readings are held
    assign full = (count_reg == DEPTH);
    assign popNow = (state_reg == ST_DRAIN) && !outValid_reg && (remain_reg != IDX_ZERO)
                    && (count_reg != IDX_ZERO);
    // a pop in the same cycle frees the slot, so no loss then
    assign overflow = rdgValid && full && !popNow;
    assign scanHit = (state_reg == ST_LSCAN) && (scanLeft_reg != IDX_ZERO)
                     && (dataB.chan == reqChan_reg);
    assign scanDone = (scanLeft_reg == IDX_ZERO)
                      || (scanHit && (IDXW'(found_reg + IDX_ONE) == reqNum_reg));
    assign emitHit = (state_reg == ST_LEMIT) && !outValid_reg && (remain_reg != IDX_ZERO)
                     && (dataB.chan == reqChan_reg);

    rmb_store u_store (
        .sys_clk(sys_clk),
        .wrEn(rdgValid),
        .wrIdx(wrPtr_reg),
        .wrData(rdgIn),
        .idxA(rdPtr_reg),
        .idxB(scanIdx_reg),
        .dataA(dataA),
        .dataB(dataB)
    );

    always_comb
    begin
        count_next = count_reg;
        if (rdgValid && !popNow && !full)
            count_next = IDXW'(count_reg + IDX_ONE);
        else if (popNow && !rdgValid)
            count_next = IDXW'(count_reg - IDX_ONE);
    end

    assign thrHit = (count_next >= threshold_reg) && (count_reg < threshold_reg);

    // write pointer wraps at the store depth
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrPtr_reg <= IDX_ZERO;
            rdPtr_reg <= IDX_ZERO;
            count_reg <= IDX_ZERO;
        end
        else
        begin
            if (rdgValid)
                wrPtr_reg <= nextIdx(wrPtr_reg);
            // oldest slot is dropped on overwrite
            if (popNow || overflow)
                rdPtr_reg <= nextIdx(rdPtr_reg);
            count_reg <= count_next;
        end
    end

    // Host-written request parameters and threshold
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reqNum_reg <= IDX_ONE;
            reqChan_reg <= 16'h0000;
            threshold_reg <= THR_RST;
        end
        else if (busWr)
        begin
            if (wbReq.adr == OFF_NUM)
                reqNum_reg <= numMerge[IDXW-1:0];
            if (wbReq.adr == OFF_CHAN)
                reqChan_reg <= chanMerge[15:0];
            if (wbReq.adr == OFF_THR && thrMerge != 32'h00000000 && thrMerge <= 32'(DEPTH))
                threshold_reg <= thrMerge[IDXW-1:0];
        end
    end

    // Command engine
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            remain_reg <= IDX_ZERO;
            scanIdx_reg <= IDX_ZERO;
            scanLeft_reg <= IDX_ZERO;
            found_reg <= IDX_ZERO;
            startIdx_reg <= IDX_ZERO;
            err_reg <= 1'b0;
            errPulse_reg <= 1'b0;
        end
        else
        begin
            errPulse_reg <= 1'b0;
            if (clsCmd)
                err_reg <= 1'b0;
            unique case (state_reg)
                ST_IDLE:
                begin
                    if (cmdGo)
                    begin
                        err_reg <= 1'b0;
                        if (numBad || cmdOp == OP_NONE)
                        begin
                            err_reg <= 1'b1;
                            errPulse_reg <= 1'b1;
                        end
                        else if (cmdOp == OP_DRAIN)
                        begin
                            if (reqNum_reg <= count_reg)
                            begin
                                state_reg <= ST_DRAIN;
                                remain_reg <= reqNum_reg;
                            end
                            // park until enough readings are held
                            else if (cmdWait)
                                state_reg <= ST_WAITN;
                            // too few readings and no wait
                            else
                            begin
                                err_reg <= 1'b1;
                                errPulse_reg <= 1'b1;
                            end
                        end
                        // only what is already held, no waiting
                        else if (cmdOp == OP_AVAIL)
                        begin
                            if (count_reg != IDX_ZERO)
                            begin
                                state_reg <= ST_DRAIN;
                                remain_reg <= (reqNum_reg < count_reg) ? reqNum_reg : count_reg;
                            end
                        end
                        else if (reqNum_reg > LAST_MAX)
                        begin
                            err_reg <= 1'b1;
                            errPulse_reg <= 1'b1;
                        end
                        else
                        begin
                            state_reg <= ST_LSCAN;
                            scanIdx_reg <= prevIdx(wrPtr_reg);
                            scanLeft_reg <= count_reg;
                            found_reg <= IDX_ZERO;
                        end
                    end
                end
                // released once the count is reached
                ST_WAITN:
                begin
                    if (count_reg >= reqNum_reg)
                    begin
                        state_reg <= ST_DRAIN;
                        remain_reg <= reqNum_reg;
                    end
                end
                // one reading per pop, oldest first
                ST_DRAIN:
                begin
                    if (remain_reg == IDX_ZERO)
                        state_reg <= ST_IDLE;
                    else if (popNow)
                        remain_reg <= IDXW'(remain_reg - IDX_ONE);
                end
                // Walks back from the newest; overwrites during the walk are not tracked
                ST_LSCAN:
                begin
                    if (scanDone)
                    begin
                        if (found_reg == IDX_ZERO && !scanHit)
                        begin
                            state_reg <= ST_IDLE;
                            err_reg <= 1'b1;
                            errPulse_reg <= 1'b1;
                        end
                        else
                        begin
                            state_reg <= ST_LEMIT;
                            remain_reg <= IDXW'(found_reg + {16'h0000, scanHit});
                            scanIdx_reg <= scanHit ? scanIdx_reg : startIdx_reg;
                        end
                    end
                    else
                    begin
                        if (scanHit)
                        begin
                            found_reg <= IDXW'(found_reg + IDX_ONE);
                            startIdx_reg <= scanIdx_reg;
                        end
                        scanIdx_reg <= prevIdx(scanIdx_reg);
                        scanLeft_reg <= IDXW'(scanLeft_reg - IDX_ONE);
                    end
                end
                // forward from the oldest match, so newest comes last
                ST_LEMIT:
                begin
                    if (remain_reg == IDX_ZERO)
                        state_reg <= ST_IDLE;
                    else if (!outValid_reg)
                    begin
                        scanIdx_reg <= nextIdx(scanIdx_reg);
                        if (emitHit)
                            remain_reg <= IDXW'(remain_reg - IDX_ONE);
                    end
                end
            endcase
        end
    end

    // One-reading output holding register, freed by a data read
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            outData_reg <= '0;
            outValid_reg <= 1'b0;
        end
        else if (popNow)
        begin
            outData_reg <= dataA;
            outValid_reg <= 1'b1;
        end
        else if (emitHit)
        begin
            outData_reg <= dataB;
            outValid_reg <= 1'b1;
        end
        else if (dataRd)
            outValid_reg <= 1'b0;
    end

    // Status flags; set wins over clear
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            operThr_reg <= 1'b0;
            questOvf_reg <= 1'b0;
        end
        else
        begin
            if (thrHit)
                operThr_reg <= 1'b1;
            // cleared only by reading it or clear-status
            else if (operRd || clsCmd)
                operThr_reg <= 1'b0;
            // condition holds while the store stays full after a loss, until a clear-status
            if (overflow)
                questOvf_reg <= 1'b1;
            else if (clsCmd || !full)
                questOvf_reg <= 1'b0;
        end
    end

    assign irqEvt = {popNow || emitHit, errPulse_reg, overflow, thrHit};

    rmb_irq u_irq (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .evt(irqEvt),
        .w1cEn(busWr && wbReq.adr == OFF_ISTAT),
        .maskEn(busWr && wbReq.adr == OFF_IMASK),
        .wrData(wbReq.dat[NIRQ-1:0]),
        .status_reg(irqStatus),
        .mask_reg(irqMask),
        .irq_reg(irq)
    );

    // Wishbone slave: ack one cycle after the strobe, unmapped reads give zero
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wbAck_reg <= 1'b0;
            wbDatO_reg <= 32'h00000000;
        end
        else
        begin
            wbAck_reg <= busAcc;
            if (busRd)
            begin
                unique case (wbReq.adr)
                    OFF_NUM: wbDatO_reg <= 32'(reqNum_reg);
                    OFF_CHAN: wbDatO_reg <= 32'(reqChan_reg);
                    OFF_STAT: wbDatO_reg <= 32'({outValid_reg, err_reg, state_reg != ST_IDLE});
                    OFF_DATA: wbDatO_reg <= outData_reg.value;
                    OFF_DCHAN: wbDatO_reg <= 32'(outData_reg.chan);
                    // count is read without side effect
                    OFF_POINTS: wbDatO_reg <= 32'(count_reg);
                    OFF_THR: wbDatO_reg <= 32'(threshold_reg);
                    OFF_OPER: wbDatO_reg <= 32'(operThr_reg) << OPER_THR_BIT;
                    OFF_QUEST: wbDatO_reg <= 32'(questOvf_reg) << QUEST_OVF_BIT;
                    OFF_ISTAT: wbDatO_reg <= 32'(irqStatus);
                    OFF_IMASK: wbDatO_reg <= 32'(irqMask);
                    default: wbDatO_reg <= 32'h00000000;
                endcase
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_count_cap: assert property (count_reg <= DEPTH) else $error("count above capacity");
    a_drain_order: assert property (popNow |=> outData_reg == $past(dataA) && outValid_reg)
        else $error("drain not oldest first");
    a_drain_err: assert property (cmdGo && cmdOp == OP_DRAIN && !numBad && !cmdWait
        && reqNum_reg > count_reg |=> err_reg && state_reg == ST_IDLE)
        else $error("short drain without error");
    a_wait_hold: assert property (state_reg == ST_WAITN && count_reg < reqNum_reg
        |=> state_reg == ST_WAITN) else $error("wait left early");
    a_overwrite: assert property (overflow |=> count_reg == DEPTH
        && rdPtr_reg == nextIdx($past(rdPtr_reg))) else $error("overwrite wrong");
    a_ovf_flag: assert property (overflow |=> questOvf_reg && !errPulse_reg)
        else $error("overflow flag missing");
    a_thr_range: assert property (threshold_reg != IDX_ZERO && threshold_reg <= DEPTH)
        else $error("threshold out of range");
    a_thr_event: assert property (thrHit |=> operThr_reg ##1 operThr_reg || $past(operRd || clsCmd))
        else $error("threshold event lost");
    a_thr_hold: assert property (operThr_reg && !operRd && !clsCmd |=> operThr_reg)
        else $error("event bit cleared early");
    a_points_read: assert property (busRd && wbReq.adr == OFF_POINTS
        |=> wbAck_reg && wbDatO_reg == 32'($past(count_reg))) else $error("bad point count");
    a_last_len: assert property (state_reg == ST_LEMIT |-> remain_reg <= LAST_MAX)
        else $error("too many newest readings");
    a_last_err: assert property (state_reg == ST_LSCAN && scanDone && found_reg == IDX_ZERO
        && !scanHit |=> err_reg ##1 state_reg == ST_IDLE || $past(cmdGo)) else $error("missing chan error");
    a_avail_now: assert property (cmdGo && cmdOp == OP_AVAIL && !numBad && count_reg != IDX_ZERO
        |=> state_reg == ST_DRAIN && remain_reg <= $past(count_reg)) else $error("avail waited");
    a_count_dec: assert property (popNow && !rdgValid |=> count_reg == IDXW'($past(count_reg) - IDX_ONE))
        else $error("count not decremented");

    c_overflow: cover property (overflow);
    c_thr_hit: cover property (thrHit);
    c_wait_done: cover property (state_reg == ST_WAITN ##1 state_reg == ST_DRAIN);
    c_last_done: cover property (state_reg == ST_LEMIT ##1 state_reg == ST_IDLE);
endmodule

// ===== design/rmb_pkg.sv
// Shared constants and types for the reading memory buffer.
// Assumes one 125 MHz system clock and a classic Wishbone register bus.
package rmb_pkg;
    localparam int DEPTH_N = 100000;
    localparam int IDXW = 17;
    localparam logic [IDXW-1:0] DEPTH = 17'h186A0;
    localparam logic [IDXW-1:0] DEPTH_M1 = 17'h1869F;
    localparam logic [IDXW-1:0] LAST_MAX = 17'h003E8;
    localparam logic [IDXW-1:0] THR_RST = 17'h00001;
    localparam logic [IDXW-1:0] IDX_ZERO = 17'h00000;
    localparam logic [IDXW-1:0] IDX_ONE = 17'h00001;

    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_NUM = 8'h04;
    localparam logic [7:0] OFF_CHAN = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0C;
    localparam logic [7:0] OFF_DATA = 8'h10;
    localparam logic [7:0] OFF_DCHAN = 8'h14;
    localparam logic [7:0] OFF_POINTS = 8'h18;
    localparam logic [7:0] OFF_THR = 8'h1C;
    localparam logic [7:0] OFF_OPER = 8'h20;
    localparam logic [7:0] OFF_QUEST = 8'h24;
    localparam logic [7:0] OFF_ISTAT = 8'h28;
    localparam logic [7:0] OFF_IMASK = 8'h2C;

    localparam int CMD_OP_LSB = 0;
    localparam int CMD_WAIT_BIT = 2;
    localparam int CMD_CLS_BIT = 3;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ERR_BIT = 1;
    localparam int STAT_VALID_BIT = 2;
    localparam int OPER_THR_BIT = 9;
    localparam int QUEST_OVF_BIT = 12;
    localparam int NIRQ = 4;
    localparam int IRQ_THR = 0;
    localparam int IRQ_OVF = 1;
    localparam int IRQ_ERR = 2;
    localparam int IRQ_DATA = 3;

    typedef enum logic [1:0] {OP_DRAIN, OP_AVAIL, OP_LAST, OP_NONE} rmb_op_e;

    typedef struct packed {
        logic [15:0] chan;
        logic [31:0] value;
    } rmb_reading_s;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } rmb_wb_req_s;
endpackage

// ===== design/rmb_store.sv
// Circular reading store: one write port, two combinational read ports.
// Assumes indices stay below the store depth.
`timescale 1ns/10ps
module rmb_store (
    input wire logic sys_clk,
    input wire logic wrEn,
    input wire logic [rmb_pkg::IDXW-1:0] wrIdx,
    input rmb_pkg::rmb_reading_s wrData,
    input wire logic [rmb_pkg::IDXW-1:0] idxA,
    input wire logic [rmb_pkg::IDXW-1:0] idxB,
    output rmb_pkg::rmb_reading_s dataA,
    output rmb_pkg::rmb_reading_s dataB
);
    import rmb_pkg::*;

    // Data only, so no reset: pointers decide what is valid
    rmb_reading_s mem [DEPTH_N];

    always_ff @(posedge sys_clk)
    begin
        if (wrEn)
        begin
            mem[wrIdx] <= wrData;
        end
    end

    assign dataA = mem[idxA];
    assign dataB = mem[idxB];
endmodule

// ===== design/rmb_irq.sv
// Sticky interrupt status with write-one-to-clear, mask and level output.
// Assumes event inputs are single-cycle pulses in the sys_clk domain.
`timescale 1ns/10ps
module rmb_irq (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [rmb_pkg::NIRQ-1:0] evt,
    input wire logic w1cEn,
    input wire logic maskEn,
    input wire logic [rmb_pkg::NIRQ-1:0] wrData,
    output logic [rmb_pkg::NIRQ-1:0] status_reg,
    output logic [rmb_pkg::NIRQ-1:0] mask_reg,
    output logic irq_reg
);
    import rmb_pkg::*;

    genvar i;
    generate
        for (i = 0; i < NIRQ; i++)
        begin : g_bit
            // A new event beats a clear in the same cycle
            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                if (!rst_n)
                    status_reg[i] <= 1'b0;
                else if (evt[i])
                    status_reg[i] <= 1'b1;
                else if (w1cEn && wrData[i])
                    status_reg[i] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            mask_reg <= '0;
        else if (maskEn)
            mask_reg <= wrData;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_reg <= 1'b0;
        else
            irq_reg <= |(status_reg & mask_reg);
    end
endmodule

// ===== bench/rmb_engine_model.sv
// Measurement engine model: one reading per strobe, never back to back.
// Assumes the bench calls push from its main sequence only.
`timescale 1ns/10ps
module rmb_engine_model
    import rmb_pkg::*;
(
    input wire logic sys_clk,
    output logic rdgValid,
    output rmb_pkg::rmb_reading_s rdgIn
);
    initial
    begin
        rdgValid = 1'h0;
        rdgIn = '0;
    end

    task automatic push(input logic [15:0] ch, input logic [31:0] v);
        @(posedge sys_clk);
        rdgValid <= 1'h1;
        rdgIn <= '{ch, v};
        @(posedge sys_clk);
        rdgValid <= 1'h0;
        // Invert stale data so nothing latches it by luck
        rdgIn <= ~rdgIn;
    endtask
endmodule

// ===== bench/testbench.sv
// Self-checking bench for the reading memory over classic Wishbone.
// Assumes the design acks every request within a few cycles.
`timescale 1ns/10ps
module testbench;
    import rmb_pkg::*;
    logic sysClk, rstN, wbAck, rdgValid, irq;
    logic [31:0] wbDat, rd, lfsrState;
    rmb_wb_req_s req;
    rmb_reading_s rdgIn;
    int mismatches, cmp_count, cycles;
    logic [31:0] expQ[$];

    rmb_reading_memory dut (.sys_clk(sysClk), .rst_n(rstN), .wbReq(req), .wbAck_reg(wbAck),
        .wbDatO_reg(wbDat), .rdgValid(rdgValid), .rdgIn(rdgIn), .irq(irq));
    rmb_engine_model eng (.sys_clk(sysClk), .rdgValid(rdgValid), .rdgIn(rdgIn));

    initial
    begin
        sysClk = 1'h0;
        forever #4 sysClk = ~sysClk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge sysClk);
        req <= '{1'h1, 1'h1, we, 4'hF, adr, dat};
        do @(posedge sysClk); while (wbAck !== 1'h1);
        rd = wbDat;
        req <= '0;
    endtask

    // drained well before the store can fill
    // Poll for each result, then pop it and compare with the oldest expected
    task automatic take(input int n);
        int t;
        repeat (n)
        begin
            t = 0;
            do
            begin
                wb(1'h0, OFF_STAT, 32'h0);
                t++;
            end
            while (rd[STAT_VALID_BIT] !== 1'h1 && t < 40);
            wb(1'h0, OFF_DATA, 32'h0);
            chk(rd, expQ.pop_front());
        end
    endtask

    // A newest-readings scan takes one cycle per held reading, so wait it out
    task automatic wait_idle;
        int t;
        t = 0;
        do
        begin
            wb(1'h0, OFF_STAT, 32'h0);
            t++;
        end
        while (rd[STAT_BUSY_BIT] !== 1'h0 && t < 40);
    endtask

    task automatic fill(input int n);
        repeat (n)
        begin
            lfsrState = lfsr(lfsrState);
            eng.push(16'h0065, lfsrState);
            expQ.push_back(lfsrState);
        end
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge sysClk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            stop_test();
        end
    end

    initial
    begin
        req = '0;
        rstN = 1'h0;
        lfsrState = 32'h3BB2;
        repeat (5) @(posedge sysClk);
        rstN <= 1'h1;
        wb(1'h0, OFF_THR, 32'h0);
        chk(rd, 32'h1);
        wb(1'h1, OFF_THR, 32'h3);
        wb(1'h1, OFF_THR, 32'h0);
        wb(1'h0, OFF_THR, 32'h0);
        chk(rd, 32'h3);
        fill(5);
        wb(1'h0, OFF_POINTS, 32'h0);
        chk(rd, 32'h5);
        wb(1'h0, OFF_OPER, 32'h0);
        chk(32'(rd[OPER_THR_BIT]), 32'h1);
        wb(1'h0, OFF_OPER, 32'h0);
        chk(32'(rd[OPER_THR_BIT]), 32'h0);
        $display("test fill and threshold done");
        wb(1'h1, OFF_NUM, 32'h2);
        wb(1'h1, OFF_CMD, 32'h0);
        take(2);
        wb(1'h0, OFF_POINTS, 32'h0);
        chk(rd, 32'h3);
        wb(1'h1, OFF_NUM, 32'h1);
        wb(1'h1, OFF_CHAN, 32'h65);
        wb(1'h1, OFF_CMD, 32'h2);
        expQ.push_front(lfsrState);
        take(1);
        wb(1'h1, OFF_IMASK, 32'h4);
        wb(1'h1, OFF_CHAN, 32'h7);
        wb(1'h1, OFF_CMD, 32'h2);
        wait_idle();
        chk(32'(rd[STAT_ERR_BIT]), 32'h1);
        wb(1'h0, OFF_ISTAT, 32'h0);
        chk(32'(rd[IRQ_ERR]), 32'h1);
        chk(32'(irq), 32'h1);
        wb(1'h1, OFF_ISTAT, 32'hF);
        wb(1'h1, OFF_CMD, 32'h8);
        wb(1'h0, OFF_STAT, 32'h0);
        chk(32'(irq), 32'h0);
        $display("test drain and newest done");
        wb(1'h1, OFF_NUM, 32'h32);
        wb(1'h1, OFF_CMD, 32'h0);
        wb(1'h0, OFF_STAT, 32'h0);
        chk(32'(rd[STAT_ERR_BIT]), 32'h1);
        wb(1'h1, OFF_CMD, 32'h8);
        wb(1'h1, OFF_CMD, 32'h1);
        take(3);
        wb(1'h0, OFF_POINTS, 32'h0);
        chk(rd, 32'h0);
        wb(1'h0, 8'h3C, 32'h0);
        chk(rd, 32'h0);
        wb(1'h0, OFF_QUEST, 32'h0);
        chk(rd, 32'h0);
        wb(1'h1, OFF_NUM, 32'h2);
        wb(1'h1, OFF_CMD, 32'h4);
        fill(2);
        take(2);
        wb(1'h1, OFF_CMD, 32'h3);
        wb(1'h0, OFF_STAT, 32'h0);
        chk(32'(rd[STAT_ERR_BIT]), 32'h1);
        wb(1'h1, OFF_CMD, 32'h8);
        wb(1'h1, OFF_NUM, 32'h0);
        wb(1'h1, OFF_CMD, 32'h0);
        wb(1'h0, OFF_STAT, 32'h0);
        chk(32'(rd[STAT_ERR_BIT]), 32'h1);
        $display("test error and wait done");
        stop_test();
    end
endmodule
